// File: prc_top.sv
// Priority allocation register with peripheral write alias clearing
module prc_top
  import prc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic cfg_req,
  input wire logic cfg_wr,
  input wire logic cfg_dma,
  input wire logic [PRC_AW-1:0] cfg_addr,
  input wire logic [PRC_DW-1:0] cfg_wdata,
  output logic cfg_ack,
  output logic [PRC_DW-1:0] cfg_rdata,
  input wire logic dbus_req,
  input wire logic dbus_wr,
  input wire logic dbus_dma,
  input wire logic [PRC_DW-1:0] dbus_wdata,
  output logic dbus_ack,
  output logic [PRC_DW-1:0] dbus_rdata,
  output logic [PRC_DW-1:0] priority_allocation
);
  prc_reg_if rif();

  prc_periph_regs u_store (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .rif(rif)
  );

  logic [PRC_DW-1:0] prio_reg, prio_next;
  logic cfg_ack_reg, cfg_ack_next;
  logic [PRC_DW-1:0] cfg_rdata_reg, cfg_rdata_next;
  logic dbus_ack_reg, dbus_ack_next;
  logic [PRC_DW-1:0] dbus_rdata_reg, dbus_rdata_next;

  logic cfg_take, dbus_take, dbus_blocked;
  logic hit_prio, hit_periph, alias_clear;
  logic [PRC_IW-1:0] hit_idx;

  // Address decode of the configuration bus
  always_comb begin
    hit_prio = (cfg_addr == PRC_ADDR_PRIO);
    hit_periph = 1'b1;
    hit_idx = PRC_IDX_PCI;
    unique case (cfg_addr)
      PRC_ADDR_PCI: hit_idx = PRC_IDX_PCI;
      PRC_ADDR_SERIAL: hit_idx = PRC_IDX_SERIAL;
      PRC_ADDR_HOST: hit_idx = PRC_IDX_HOST;
      PRC_ADDR_MAC: hit_idx = PRC_IDX_MAC;
      default: hit_periph = 1'b0;
    endcase
  end

  // One request per ack; the requester holds req until ack
  assign cfg_take = ce && cfg_req && !cfg_ack_reg;
  // Any configuration peripheral write owns the single store port; data bus waits
  assign dbus_blocked = cfg_take && cfg_wr && hit_periph;
  assign dbus_take = ce && dbus_req && !dbus_ack_reg && !dbus_blocked;
  // Decode flaw: every peripheral write on this bus clears priority
  assign alias_clear = cfg_take && cfg_wr && hit_periph;

  // Store port steering
  always_comb begin
    rif.wr_en = 1'b0;
    rif.wr_idx = PRC_IDX_SERIAL;
    rif.wr_data = dbus_wdata;
    rif.rd_idx = hit_idx;
    if (cfg_take && cfg_wr && hit_periph) begin
      rif.wr_en = 1'b1;
      rif.wr_idx = hit_idx;
      rif.wr_data = cfg_wdata;
    end else if (dbus_take && dbus_wr) begin
      rif.wr_en = 1'b1;
    end
  end

  // Priority allocation next value
  always_comb begin
    prio_next = prio_reg;
    if (alias_clear) begin
      prio_next = PRC_CLEARED;
    end else if (cfg_take && cfg_wr && hit_prio) begin
      prio_next = cfg_wdata;
    end
  end

  // Bus answers
  always_comb begin
    cfg_ack_next = cfg_take;
    cfg_rdata_next = cfg_rdata_reg;
    if (cfg_take && !cfg_wr) begin
      if (hit_prio) begin
        cfg_rdata_next = prio_reg;
      end else if (hit_periph) begin
        cfg_rdata_next = rif.rd_data;
      end else begin
        cfg_rdata_next = PRC_UNMAPPED_RD;
      end
    end
    dbus_ack_next = dbus_take;
    dbus_rdata_next = dbus_rdata_reg;
    if (dbus_take && !dbus_wr) begin
      dbus_rdata_next = rif.serial_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prio_reg <= PRC_PRIO_RESET;
      cfg_ack_reg <= 1'b0;
      cfg_rdata_reg <= PRC_UNMAPPED_RD;
      dbus_ack_reg <= 1'b0;
      dbus_rdata_reg <= PRC_UNMAPPED_RD;
    end else if (ce) begin
      prio_reg <= prio_next;
      cfg_ack_reg <= cfg_ack_next;
      cfg_rdata_reg <= cfg_rdata_next;
      dbus_ack_reg <= dbus_ack_next;
      dbus_rdata_reg <= dbus_rdata_next;
    end
  end

  assign cfg_ack = cfg_ack_reg;
  assign cfg_rdata = cfg_rdata_reg;
  assign dbus_ack = dbus_ack_reg;
  assign dbus_rdata = dbus_rdata_reg;
  assign priority_allocation = prio_reg;

  // Checks
  sequence s_cfg_wr(logic [PRC_AW-1:0] a);
    cfg_take && cfg_wr && cfg_addr == a;
  endsequence

  sequence s_cleared;
    priority_allocation == PRC_CLEARED ##0 cfg_ack;
  endsequence

  a_prio_program: assert property (@(posedge clk) disable iff (rst)
    s_cfg_wr(PRC_ADDR_PRIO) |=> priority_allocation == $past(cfg_wdata) && cfg_ack)
    else $error("priority allocation write not stored");
  a_pci_clear: assert property (@(posedge clk) disable iff (rst)
    s_cfg_wr(PRC_ADDR_PCI) |=> s_cleared)
    else $error("PCI command write did not clear priority");
  a_serial_clear: assert property (@(posedge clk) disable iff (rst)
    s_cfg_wr(PRC_ADDR_SERIAL) |=> s_cleared)
    else $error("serial config write did not clear priority");
  a_host_clear: assert property (@(posedge clk) disable iff (rst)
    s_cfg_wr(PRC_ADDR_HOST) |=> s_cleared)
    else $error("host port write did not clear priority");
  a_mac_clear: assert property (@(posedge clk) disable iff (rst)
    s_cfg_wr(PRC_ADDR_MAC) |=> s_cleared)
    else $error("MAC control write did not clear priority");
  a_prio_one_way: assert property (@(posedge clk) disable iff (rst)
    s_cfg_wr(PRC_ADDR_PRIO) |-> !rif.wr_en || rif.wr_idx == PRC_IDX_SERIAL && !cfg_ack_reg
      && dbus_take && dbus_wr)
    else $error("priority write touched a peripheral register");
  a_periph_read: assert property (@(posedge clk) disable iff (rst)
    cfg_take && !cfg_wr && hit_periph |=> cfg_ack && cfg_rdata == $past(rif.rd_data))
    else $error("peripheral read returned wrong value");
  a_dbus_serial: assert property (@(posedge clk) disable iff (rst)
    dbus_take && dbus_wr |=> dbus_ack && rif.serial_data == $past(dbus_wdata))
    else $error("data bus write did not reach serial register");
  a_dbus_no_clear: assert property (@(posedge clk) disable iff (rst)
    dbus_take && !cfg_take |=> $stable(priority_allocation))
    else $error("data bus write disturbed priority");
  a_clear_whole: assert property (@(posedge clk) disable iff (rst)
    alias_clear |=> priority_allocation == PRC_CLEARED && $past(cfg_ack_reg) == 1'b0)
    else $error("clear was not whole or not on the accepting edge");
endmodule // prc_top

// File: prc_pkg.sv
// Package of addresses, indexes, reset values and widths for the priority allocation bank
// How it works
// - Priority allocation register holds system bus priority of peripheral masters.
// - Configuration write to PCI command/status also clears priority allocation.
// - Configuration write to serial transmit data also clears priority allocation.
// - Write to host port power/emulation register also clears priority allocation.
// - Write to MAC transmit control also clears priority allocation.
// - Writing priority allocation leaves the four peripheral registers unchanged.
// - Reads of peripheral registers return their own contents, not priority.
// - Serial transmit data reachable over configuration bus and data bus.
// - Data bus writes to serial transmit data never disturb priority allocation.
package prc_pkg;
  localparam int PRC_DW = 32;
  localparam int PRC_AW = 32;
  localparam int PRC_NREG = 4;
  localparam int PRC_IW = 2;
  localparam logic [PRC_AW-1:0] PRC_ADDR_PRIO = 32'h029a_0000;
  localparam logic [PRC_AW-1:0] PRC_ADDR_PCI = 32'h02c0_0004;
  localparam logic [PRC_AW-1:0] PRC_ADDR_SERIAL = 32'h0290_0004;
  localparam logic [PRC_AW-1:0] PRC_ADDR_HOST = 32'h0288_0004;
  localparam logic [PRC_AW-1:0] PRC_ADDR_MAC = 32'h02c8_0004;
  localparam logic [PRC_IW-1:0] PRC_IDX_PCI = 2'h0;
  localparam logic [PRC_IW-1:0] PRC_IDX_SERIAL = 2'h1;
  localparam logic [PRC_IW-1:0] PRC_IDX_HOST = 2'h2;
  localparam logic [PRC_IW-1:0] PRC_IDX_MAC = 2'h3;
  localparam logic [PRC_DW-1:0] PRC_PRIO_RESET = 32'h0000_0000;
  localparam logic [PRC_DW-1:0] PRC_PERIPH_RESET = 32'h0000_0000;
  localparam logic [PRC_DW-1:0] PRC_CLEARED = 32'h0000_0000;
  localparam logic [PRC_DW-1:0] PRC_UNMAPPED_RD = 32'h0000_0000;
endpackage

// File: prc_reg_if.sv
// Interface between the bus decoder and the peripheral register store
interface prc_reg_if;
  import prc_pkg::*;
  logic wr_en;
  logic [PRC_IW-1:0] wr_idx;
  logic [PRC_DW-1:0] wr_data;
  logic [PRC_IW-1:0] rd_idx;
  logic [PRC_DW-1:0] rd_data;
  logic [PRC_DW-1:0] serial_data;
  modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx,
                input rd_data, input serial_data);
  modport store (input wr_en, input wr_idx, input wr_data, input rd_idx,
                 output rd_data, output serial_data);
endinterface

// File: prc_periph_regs.sv
// Flip-flop store for the four peripheral registers, one write and two read ports
module prc_periph_regs
  import prc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  prc_reg_if.store rif
);
  logic [PRC_DW-1:0] store_reg [PRC_NREG];
  logic [PRC_DW-1:0] store_next [PRC_NREG];

  genvar gi;
  generate
    for (gi = 0; gi < PRC_NREG; gi++) begin : g_entry
      always_comb begin
        store_next[gi] = store_reg[gi];
        if (rif.wr_en && (rif.wr_idx == PRC_IW'(gi))) begin
          store_next[gi] = rif.wr_data;
        end
      end
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          store_reg[gi] <= PRC_PERIPH_RESET;
        end else if (ce) begin
          store_reg[gi] <= store_next[gi];
        end
      end
    end
  endgenerate

  assign rif.rd_data = store_reg[rif.rd_idx];
  assign rif.serial_data = store_reg[PRC_IDX_SERIAL];

  a_store_write: assert property (@(posedge clk) disable iff (rst)
    ce && rif.wr_en |=> store_reg[$past(rif.wr_idx)] == $past(rif.wr_data))
    else $error("peripheral register did not take write");
endmodule // prc_periph_regs

// File: prc_cfg_master.sv
// Configuration bus master model for the CPU and DMA controller
module prc_cfg_master
  import prc_pkg::*;
(
  input wire logic clk,
  output logic cfg_req,
  output logic cfg_wr,
  output logic cfg_dma,
  output logic [PRC_AW-1:0] cfg_addr,
  output logic [PRC_DW-1:0] cfg_wdata,
  input wire logic cfg_ack,
  input wire logic [PRC_DW-1:0] cfg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cfg_req = 1'b0;
    cfg_wr = 1'b0;
    cfg_dma = 1'b0;
    cfg_addr = '0;
    cfg_wdata = '0;
  end
  // Released address and write data lines show the inverse, so stale values never pass for data
  task automatic op(input logic wr, input logic dma, input logic [PRC_AW-1:0] a,
      input logic [PRC_DW-1:0] d, output logic [PRC_DW-1:0] q, output bit ok);
    ok = 1'b0;
    q = '0;
    @(posedge clk);
    cfg_req <= 1'b1;
    cfg_wr <= wr;
    cfg_dma <= dma;
    cfg_addr <= a;
    cfg_wdata <= d;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge clk);
      if (cfg_ack === 1'b1) begin
        ok = 1'b1;
        q = cfg_rdata;
      end
    end
    cfg_req <= 1'b0;
    cfg_addr <= ~a;
    cfg_wdata <= ~d;
  endtask
  // Save, aliasing write, restore; costs two extra transfers
  task automatic guarded_wr(input logic dma, input logic [PRC_AW-1:0] a,
      input logic [PRC_DW-1:0] d, output bit ok);
    logic [PRC_DW-1:0] saved;
    logic [PRC_DW-1:0] q;
    bit ok1;
    bit ok2;
    op(1'b0, dma, PRC_ADDR_PRIO, '0, saved, ok1);
    op(1'b1, dma, a, d, q, ok2);
    op(1'b1, dma, PRC_ADDR_PRIO, saved, q, ok);
    ok = ok & ok1 & ok2;
  endtask
endmodule // prc_cfg_master

// File: tb_prc_top.sv
// Self-checking testbench for the priority allocation bank
module tb_prc_top
  import prc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic cfg_req, cfg_wr, cfg_dma, cfg_ack, dbus_ack;
  logic dbus_req = 1'b0;
  logic dbus_wr = 1'b0;
  logic dbus_dma = 1'b0;
  logic [PRC_AW-1:0] cfg_addr;
  logic [PRC_DW-1:0] cfg_wdata, cfg_rdata, dbus_rdata, priority_allocation;
  logic [PRC_DW-1:0] dbus_wdata = '0;
  logic [PRC_AW-1:0] addrs [4] = '{PRC_ADDR_PCI, PRC_ADDR_SERIAL, PRC_ADDR_HOST, PRC_ADDR_MAC};
  int n_errors = 0;
  int n_tests = 0;
  int seed = 32'hb158;
  prc_top dut (.clk(clk), .rst(rst), .ce(ce), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
    .cfg_dma(cfg_dma), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata), .dbus_req(dbus_req), .dbus_wr(dbus_wr), .dbus_dma(dbus_dma),
    .dbus_wdata(dbus_wdata), .dbus_ack(dbus_ack), .dbus_rdata(dbus_rdata),
    .priority_allocation(priority_allocation));
  prc_cfg_master master (.clk(clk), .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_dma(cfg_dma),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));
  initial forever #50 clk = ~clk;
  function automatic logic [PRC_DW-1:0] prio_after(input logic [PRC_AW-1:0] a,
      input logic [PRC_DW-1:0] old);
    return (a inside {PRC_ADDR_PCI, PRC_ADDR_SERIAL, PRC_ADDR_HOST, PRC_ADDR_MAC}) ?
      PRC_CLEARED : old;
  endfunction
  task automatic wrap_up;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [PRC_DW-1:0] got, input logic [PRC_DW-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cfg(input logic wr, input logic [PRC_AW-1:0] a,
      input logic [PRC_DW-1:0] d, output logic [PRC_DW-1:0] q);
    bit ok;
    master.op(wr, 1'($random(seed)), a, d, q, ok);
    if (!ok) begin
      n_errors++;
      $display("mismatch at %0t: ack %h expected %h", $time, 1'b0, 1'b1);
      wrap_up;
    end
  endtask
  // Save, aliasing write, restore through the partner model
  task automatic guarded(input logic [PRC_AW-1:0] a, input logic [PRC_DW-1:0] d);
    bit ok;
    master.guarded_wr(1'($random(seed)), a, d, ok);
    if (!ok) begin
      n_errors++;
      $display("mismatch at %0t: ack %h expected %h", $time, 1'b0, 1'b1);
      wrap_up;
    end
  endtask
  // Data bus master; same hold-until-ack discipline as the config side
  task automatic dbus(input logic wr, input logic [PRC_DW-1:0] d, output logic [PRC_DW-1:0] q);
    bit ok;
    ok = 1'b0;
    q = '0;
    @(posedge clk);
    dbus_req <= 1'b1;
    dbus_wr <= wr;
    dbus_dma <= 1'($random(seed));
    dbus_wdata <= d;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge clk);
      if (dbus_ack === 1'b1) begin
        ok = 1'b1;
        q = dbus_rdata;
      end
    end
    dbus_req <= 1'b0;
    dbus_wdata <= ~d;
    if (!ok) begin
      n_errors++;
      $display("mismatch at %0t: ack %h expected %h", $time, 1'b0, 1'b1);
      wrap_up;
    end
  endtask
  initial begin
    logic [PRC_DW-1:0] p, d, q;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    chk(priority_allocation, PRC_PRIO_RESET);
    foreach (addrs[i]) begin
      p = $random(seed) | 32'h1;
      d = $random(seed);
      cfg(1'b1, PRC_ADDR_PRIO, p, q);
      chk(priority_allocation, p);
      cfg(1'b1, addrs[i], d, q);
      chk(priority_allocation, prio_after(addrs[i], p));
      cfg(1'b1, PRC_ADDR_PRIO, ~p, q);
      cfg(1'b0, addrs[i], '0, q);
      chk(q, d);
    end
    p = $random(seed) | 32'h1;
    d = $random(seed);
    cfg(1'b1, PRC_ADDR_PRIO, p, q);
    dbus(1'b1, d, q);
    chk(priority_allocation, p);
    dbus(1'b0, '0, q);
    chk(q, d);
    cfg(1'b0, PRC_ADDR_SERIAL, '0, q);
    chk(q, d);
    guarded(PRC_ADDR_SERIAL, ~d);
    chk(priority_allocation, p);
    cfg(1'b0, PRC_ADDR_SERIAL, '0, q);
    chk(q, ~d);
    guarded(PRC_ADDR_HOST, d);
    chk(priority_allocation, p);
    // Enable low holds a waiting request off until it returns
    ce <= 1'b0;
    fork
      cfg(1'b1, PRC_ADDR_PCI, d, q);
      begin
        repeat (3) @(posedge clk);
        chk(priority_allocation, p);
        ce <= 1'b1;
      end
    join
    chk(priority_allocation, PRC_CLEARED);
    // Reset in mid-run brings priority and peripheral store back to reset values
    cfg(1'b1, PRC_ADDR_PRIO, p, q);
    chk(priority_allocation, p);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    chk(priority_allocation, PRC_PRIO_RESET);
    cfg(1'b0, PRC_ADDR_PCI, '0, q);
    chk(q, PRC_PERIPH_RESET);
    // Unmapped writes are ignored, unmapped reads answer with a fixed word
    cfg(1'b1, PRC_ADDR_PRIO, p, q);
    cfg(1'b1, 32'h0290_0100, d, q);
    chk(priority_allocation, p);
    cfg(1'b0, 32'h0290_0100, '0, q);
    chk(q, PRC_UNMAPPED_RD);
    wrap_up;
  end
endmodule // tb_prc_top
